// ===== inc/i2c_arb_pkg.sv
package i2c_arb_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int QUARTER_NS    = 2500;
	// least time per quarter bit, rounded up to whole cycles
	localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// sequence layout
	// ------------------------------------------------------------
	localparam logic [1:0] PH_FIRST      = 2'h0;
	localparam logic [1:0] PH_SCL_RISE   = 2'h1;
	localparam logic [1:0] PH_SAMPLE     = 2'h2;
	localparam logic [1:0] PH_LAST_START = 2'h2;
	localparam logic [1:0] PH_LAST_STOP  = 2'h2;
	localparam logic [1:0] PH_LAST_BIT   = 2'h3;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam logic [3:0] BIT_FIRST     = 4'h0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic LINE_RELEASED = 1'b1;
	localparam logic FLAG_CLEAR    = 1'b0;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_START  = 6'h02,
		ST_RSTART = 6'h04,
		ST_STOP   = 6'h08,
		ST_ACK    = 6'h10,
		ST_TX     = 6'h20
	} mstate_e;

endpackage

// ===== inc/i2c_mon_if.sv
`timescale 1ns/10ps
interface i2c_mon_if;
	logic scl_lvl;
	logic sda_lvl;
	logic start_tgl;
	logic stop_tgl;

	modport mon (output scl_lvl, output sda_lvl, output start_tgl, output stop_tgl);
	modport ctl (input scl_lvl, input sda_lvl, input start_tgl, input stop_tgl);
endinterface

// ===== rtl/i2c_bus_monitor.sv
`timescale 1ns/10ps
module i2c_bus_monitor (
	input  wire logic link_clk,
	input  wire logic reset,
	input  wire logic scl_in,
	input  wire logic sda_in,
	i2c_mon_if.mon    bus
);

	typedef struct packed {
		logic [1:0] rst_sy;
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic       sda_prev;
		logic       start_tgl;
		logic       stop_tgl;
	} mon_s;

	mon_s mon_q;
	mon_s mon_d;

	// ------------------------------------------------------------
	// start / stop detection on the link clock
	// ------------------------------------------------------------
	// link clock must run free: the lines are oversampled, not clocked by scl
	always_comb begin
		mon_d          = mon_q;
		mon_d.rst_sy   = {mon_q.rst_sy[0], reset};
		mon_d.scl_sy   = {mon_q.scl_sy[0], scl_in};
		mon_d.sda_sy   = {mon_q.sda_sy[0], sda_in};
		mon_d.sda_prev = mon_q.sda_sy[1];
		if (mon_q.scl_sy[1] && mon_q.sda_prev && !mon_q.sda_sy[1]) begin
			mon_d.start_tgl = !mon_q.start_tgl;
		end
		// stop is seen even after arbitration was lost
		if (mon_q.scl_sy[1] && !mon_q.sda_prev && mon_q.sda_sy[1]) begin
			mon_d.stop_tgl = !mon_q.stop_tgl;
		end
		if (mon_q.rst_sy[1]) begin
			mon_d.sda_prev  = i2c_arb_pkg::LINE_RELEASED;
			mon_d.start_tgl = i2c_arb_pkg::FLAG_CLEAR;
			mon_d.stop_tgl  = i2c_arb_pkg::FLAG_CLEAR;
		end
	end

	always_ff @(posedge link_clk) begin
		mon_q <= mon_d;
	end

	assign bus.scl_lvl   = mon_q.scl_sy[1];
	assign bus.sda_lvl   = mon_q.sda_sy[1];
	assign bus.start_tgl = mon_q.start_tgl;
	assign bus.stop_tgl  = mon_q.stop_tgl;

endmodule

// ===== rtl/i2c_arb_master.sv
`timescale 1ns/10ps
module i2c_arb_master #(
	parameter int QUARTER_CYC = i2c_arb_pkg::QUARTER_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       link_clk,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic       port_enable,
	input  wire logic       event_ie,
	input  wire logic       start_req,
	input  wire logic       rstart_req,
	input  wire logic       stop_req,
	input  wire logic       ack_req,
	input  wire logic       ack_data,
	input  wire logic       buf_wr,
	input  wire logic [7:0] buf_wdata,
	input  wire logic       event_clear,
	input  wire logic       collision_clear,
	output logic            start_seen,
	output logic            stop_seen,
	output logic            start_pend,
	output logic            rstart_pend,
	output logic            stop_pend,
	output logic            ack_pend,
	output logic            buffer_full_flag,
	output logic            bus_collision_flag,
	output logic            port_event_flag,
	output logic            port_irq,
	output logic            ack_received
);

	localparam int QCNT_W = $clog2(QUARTER_CYC + 1);
	localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QUARTER_CYC - 1);

	typedef struct packed {
		i2c_arb_pkg::mstate_e state;
		logic [QCNT_W-1:0]    qcnt;
		logic [1:0]           phase;
		logic [3:0]           bit_cnt;
		logic [7:0]           shift;
		logic                 ack_bit;
		logic                 sda_rel;
		logic                 scl_rel;
		logic                 buf_full;
		logic                 bcl;
		logic                 evt;
		logic                 irq;
		logic                 start_seen;
		logic                 stop_seen;
		logic                 start_pend;
		logic                 rstart_pend;
		logic                 stop_pend;
		logic                 ack_pend;
		logic                 ack_rx;
		logic [1:0]           scl_sy;
		logic [1:0]           sda_sy;
		logic [2:0]           start_sy;
		logic [2:0]           stop_sy;
	} ctl_s;

	localparam ctl_s CTL_RESET = '{
		state:   i2c_arb_pkg::ST_IDLE,
		sda_rel: i2c_arb_pkg::LINE_RELEASED,
		scl_rel: i2c_arb_pkg::LINE_RELEASED,
		default: '0
	};

	ctl_s st_q;
	ctl_s st_d;

	logic qend;
	logic start_evt;
	logic stop_evt;
	logic may_take;
	logic wr_ok;
	logic chk_en;
	logic coll;

	i2c_mon_if mon_bus ();

	i2c_bus_monitor u_monitor (
		.link_clk (link_clk),
		.reset    (reset),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.bus      (mon_bus)
	);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic scl_high_phase(input logic [1:0] ph);
		return (ph == i2c_arb_pkg::PH_SCL_RISE) || (ph == i2c_arb_pkg::PH_SAMPLE);
	endfunction

	assign qend      = st_q.qcnt == QCNT_LAST;
	assign start_evt = st_q.start_sy[1] ^ st_q.start_sy[2];
	assign stop_evt  = st_q.stop_sy[1] ^ st_q.stop_sy[2];
	// free bus: stop seen, or nothing seen since enable
	assign may_take  = st_q.stop_seen || (!st_q.start_seen && !st_q.stop_seen);
	assign wr_ok     = buf_wr && port_enable && st_q.state == i2c_arb_pkg::ST_IDLE &&
		!st_q.buf_full && !st_q.bcl;
	// check only where we release sda with scl released; the slave ack slot is exempt
	assign chk_en    = port_enable && qend && st_q.state != i2c_arb_pkg::ST_IDLE &&
		st_q.sda_rel && st_q.scl_rel &&
		!(st_q.state == i2c_arb_pkg::ST_TX && st_q.bit_cnt == i2c_arb_pkg::BYTE_BITS);
	assign coll      = chk_en && st_q.scl_sy[1] && !st_q.sda_sy[1];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d          = st_q;
		st_d.scl_sy   = {st_q.scl_sy[0], mon_bus.scl_lvl};
		st_d.sda_sy   = {st_q.sda_sy[0], mon_bus.sda_lvl};
		st_d.start_sy = {st_q.start_sy[1:0], mon_bus.start_tgl};
		st_d.stop_sy  = {st_q.stop_sy[1:0], mon_bus.stop_tgl};
		st_d.irq      = st_q.evt && event_ie;

		// clears first so a same-cycle set wins
		if (event_clear) begin
			st_d.evt = i2c_arb_pkg::FLAG_CLEAR;
		end
		if (collision_clear) begin
			st_d.bcl = i2c_arb_pkg::FLAG_CLEAR;
		end
		if (start_req) begin
			st_d.start_pend = 1'b1;
		end
		if (rstart_req) begin
			st_d.rstart_pend = 1'b1;
		end
		if (stop_req) begin
			st_d.stop_pend = 1'b1;
		end
		if (ack_req) begin
			st_d.ack_pend = 1'b1;
			st_d.ack_bit  = ack_data;
		end

		if (start_evt) begin
			st_d.start_seen = 1'b1;
			st_d.stop_seen  = 1'b0;
		end
		if (stop_evt) begin
			st_d.stop_seen  = 1'b1;
			st_d.start_seen = 1'b0;
			st_d.evt        = 1'b1;
		end

		// whole byte reloaded, bit position restarts
		if (wr_ok) begin
			st_d.shift    = buf_wdata;
			st_d.bit_cnt  = i2c_arb_pkg::BIT_FIRST;
			st_d.buf_full = 1'b1;
		end

		st_d.qcnt = (st_q.state == i2c_arb_pkg::ST_IDLE || qend) ? '0 : st_q.qcnt + 1'b1;
		if (st_q.state != i2c_arb_pkg::ST_IDLE && qend) begin
			st_d.phase = st_q.phase + 1'b1;
		end

		unique case (st_q.state)
			i2c_arb_pkg::ST_IDLE: begin
				st_d.phase = i2c_arb_pkg::PH_FIRST;
				// no new transfer while the collision flag stands
				if (port_enable && !st_q.bcl) begin
					if (st_q.stop_pend) begin
						st_d.state = i2c_arb_pkg::ST_STOP;
					end else if (st_q.rstart_pend) begin
						st_d.state = i2c_arb_pkg::ST_RSTART;
					end else if (st_q.start_pend && may_take) begin
						st_d.state = i2c_arb_pkg::ST_START;
					end else if (st_q.ack_pend) begin
						st_d.state = i2c_arb_pkg::ST_ACK;
					end else if (st_q.buf_full) begin
						st_d.state = i2c_arb_pkg::ST_TX;
					end
				end
			end
			i2c_arb_pkg::ST_START: begin
				st_d.sda_rel = st_q.phase == i2c_arb_pkg::PH_FIRST;
				st_d.scl_rel = st_q.phase != i2c_arb_pkg::PH_LAST_START;
				if (qend && st_q.phase == i2c_arb_pkg::PH_LAST_START) begin
					st_d.state      = i2c_arb_pkg::ST_IDLE;
					st_d.start_pend = 1'b0;
					st_d.evt        = 1'b1;
				end
			end
			i2c_arb_pkg::ST_RSTART: begin
				st_d.sda_rel = st_q.phase < i2c_arb_pkg::PH_SAMPLE;
				st_d.scl_rel = scl_high_phase(st_q.phase);
				if (qend && st_q.phase == i2c_arb_pkg::PH_LAST_BIT) begin
					st_d.state       = i2c_arb_pkg::ST_IDLE;
					st_d.rstart_pend = 1'b0;
					st_d.evt         = 1'b1;
				end
			end
			i2c_arb_pkg::ST_STOP: begin
				st_d.sda_rel = st_q.phase == i2c_arb_pkg::PH_LAST_STOP;
				st_d.scl_rel = st_q.phase != i2c_arb_pkg::PH_FIRST;
				if (qend && st_q.phase == i2c_arb_pkg::PH_LAST_STOP) begin
					st_d.state     = i2c_arb_pkg::ST_IDLE;
					st_d.stop_pend = 1'b0;
					st_d.evt       = 1'b1;
				end
			end
			i2c_arb_pkg::ST_ACK: begin
				st_d.sda_rel = st_q.ack_bit;
				st_d.scl_rel = scl_high_phase(st_q.phase);
				if (qend && st_q.phase == i2c_arb_pkg::PH_LAST_BIT) begin
					st_d.state    = i2c_arb_pkg::ST_IDLE;
					st_d.ack_pend = 1'b0;
					st_d.evt      = 1'b1;
				end
			end
			i2c_arb_pkg::ST_TX: begin
				st_d.sda_rel = (st_q.bit_cnt == i2c_arb_pkg::BYTE_BITS) || st_q.shift[7];
				st_d.scl_rel = scl_high_phase(st_q.phase);
				if (qend && st_q.phase == i2c_arb_pkg::PH_SAMPLE &&
					st_q.bit_cnt == i2c_arb_pkg::BYTE_BITS) begin
					st_d.ack_rx = st_q.sda_sy[1];
				end
				if (qend && st_q.phase == i2c_arb_pkg::PH_LAST_BIT) begin
					if (st_q.bit_cnt == i2c_arb_pkg::BYTE_BITS) begin
						st_d.state    = i2c_arb_pkg::ST_IDLE;
						st_d.buf_full = 1'b0;
						st_d.evt      = 1'b1;
					end else begin
						st_d.shift   = {st_q.shift[6:0], 1'b0};
						st_d.bit_cnt = st_q.bit_cnt + 1'b1;
					end
				end
			end
			default: begin
				st_d.state = i2c_arb_pkg::ST_IDLE;
			end
		endcase

		// lost arbitration: drop everything, release lines, flag it
		if (coll) begin
			st_d.state       = i2c_arb_pkg::ST_IDLE;
			st_d.phase       = i2c_arb_pkg::PH_FIRST;
			st_d.bit_cnt     = i2c_arb_pkg::BIT_FIRST;
			st_d.sda_rel     = i2c_arb_pkg::LINE_RELEASED;
			st_d.scl_rel     = i2c_arb_pkg::LINE_RELEASED;
			st_d.buf_full    = 1'b0;
			st_d.start_pend  = 1'b0;
			st_d.rstart_pend = 1'b0;
			st_d.stop_pend   = 1'b0;
			st_d.ack_pend    = 1'b0;
			st_d.bcl         = 1'b1;
		end

		// port off: abandon transfer, bus status forgotten
		if (!port_enable) begin
			st_d.state       = i2c_arb_pkg::ST_IDLE;
			st_d.phase       = i2c_arb_pkg::PH_FIRST;
			st_d.bit_cnt     = i2c_arb_pkg::BIT_FIRST;
			st_d.sda_rel     = i2c_arb_pkg::LINE_RELEASED;
			st_d.scl_rel     = i2c_arb_pkg::LINE_RELEASED;
			st_d.buf_full    = 1'b0;
			st_d.start_pend  = 1'b0;
			st_d.rstart_pend = 1'b0;
			st_d.stop_pend   = 1'b0;
			st_d.ack_pend    = 1'b0;
			st_d.start_seen  = 1'b0;
			st_d.stop_seen   = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_q <= CTL_RESET;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// open drain: only ever pull low
	assign scl_out            = 1'b0;
	assign sda_out            = 1'b0;
	assign scl_oe_n           = st_q.scl_rel;
	assign sda_oe_n           = st_q.sda_rel;
	assign start_seen         = st_q.start_seen;
	assign stop_seen          = st_q.stop_seen;
	assign start_pend         = st_q.start_pend;
	assign rstart_pend        = st_q.rstart_pend;
	assign stop_pend          = st_q.stop_pend;
	assign ack_pend           = st_q.ack_pend;
	assign buffer_full_flag   = st_q.buf_full;
	assign bus_collision_flag = st_q.bcl;
	assign port_event_flag    = st_q.evt;
	assign port_irq           = st_q.irq;
	assign ack_received       = st_q.ack_rx;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	chk_disable_idle: assert property (
		clk_en && !port_enable |=> st_q.state == i2c_arb_pkg::ST_IDLE && sda_oe_n && scl_oe_n)
		else $error("port not idle after disable");

	chk_seen_cleared: assert property (
		clk_en && !port_enable |=> !start_seen && !stop_seen)
		else $error("start or stop seen kept while disabled");

	chk_take_gate: assert property (
		clk_en && st_q.state == i2c_arb_pkg::ST_IDLE && st_d.state == i2c_arb_pkg::ST_START
		|-> (stop_seen || !start_seen) && !bus_collision_flag)
		else $error("start issued on a busy bus");

	chk_stop_event: assert property (
		clk_en && stop_evt && port_enable |=> port_event_flag)
		else $error("stop on bus did not set event flag");

	chk_irq_follow: assert property (
		clk_en && port_event_flag && event_ie && !event_clear |=> port_irq)
		else $error("enabled event flag gave no interrupt");

	chk_coll_scope: assert property (
		clk_en && st_q.state == i2c_arb_pkg::ST_IDLE && !bus_collision_flag
		|=> !bus_collision_flag)
		else $error("collision seen outside a bus sequence");

	chk_coll_flag: assert property (
		clk_en && port_enable && qend && st_q.state != i2c_arb_pkg::ST_IDLE && sda_oe_n &&
			scl_oe_n && !(st_q.state == i2c_arb_pkg::ST_TX && st_q.bit_cnt == 4'h8) &&
			st_q.scl_sy[1] && !st_q.sda_sy[1]
		|=> bus_collision_flag && st_q.state == i2c_arb_pkg::ST_IDLE)
		else $error("sda mismatch not flagged");

	chk_coll_release: assert property (
		clk_en && coll |=> !buffer_full_flag && sda_oe_n && scl_oe_n &&
			!start_pend && !rstart_pend && !stop_pend && !ack_pend)
		else $error("collision left lines or requests active");

	chk_bcl_hold: assert property (
		bus_collision_flag && !collision_clear |=> bus_collision_flag)
		else $error("collision flag dropped without clear");

	chk_bit_restart: assert property (
		clk_en && wr_ok |=> st_q.bit_cnt == i2c_arb_pkg::BIT_FIRST &&
			st_q.shift == $past(buf_wdata) && buffer_full_flag)
		else $error("buffer write did not restart at first bit");

endmodule

// ===== tb/i2c_bus_partner.sv
`timescale 1ns/10ps
module i2c_bus_partner (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	logic [7:0] shift_q;
	logic [7:0] got;
	logic [3:0] cnt;
	logic [3:0] grab_at;
	logic       ack_en;
	logic       ack_q;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		cnt     = 4'h0;
		grab_at = 4'hf;
		ack_en  = 1'b1;
		ack_q   = 1'b0;
		shift_q = 8'h00;
		got     = 8'h00;
	end

	// ------------------------------------------------------------
	// slave side: capture msb first, ack the ninth slot
	// ------------------------------------------------------------
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			cnt   = 4'h0;
			ack_q = 1'b0;
		end
	end

	always @(posedge scl) begin
		if (cnt < 4'h8) begin
			shift_q = {shift_q[6:0], sda};
			cnt     = cnt + 4'h1;
			if (cnt == 4'h8) begin
				got = shift_q;
			end
		end
	end

	// sda only moves while scl is low, outside start and stop
	always @(negedge scl) begin
		if (ack_q) begin
			sda_low = 1'b0;
			ack_q   = 1'b0;
			cnt     = 4'h0;
		end else if (cnt == 4'h8 && ack_en) begin
			sda_low = 1'b1;
			ack_q   = 1'b1;
		end else if (cnt == grab_at) begin
			// rival master sending a zero
			sda_low = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// rival master actions
	// ------------------------------------------------------------
	task pull_sda();
		sda_low = 1'b1;
	endtask

	// releasing with scl high makes a stop, letting the bus go free
	task free_sda();
		sda_low = 1'b0;
	endtask
endmodule

// ===== tb/i2c_multimaster_arbitration_test.sv
`timescale 1ns/10ps
module i2c_multimaster_arbitration_test;
	logic sys_clk, link_clk, reset, port_enable, event_ie, ack_data, buf_wr;
	logic start_req, rstart_req, stop_req, ack_req, event_clear, collision_clear;
	logic [7:0] buf_wdata;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, start_seen, stop_seen, port_irq;
	logic start_pend, rstart_pend, stop_pend, ack_pend, ack_received;
	logic buffer_full_flag, bus_collision_flag, port_event_flag;
	logic p_scl_low, p_sda_low;
	wire  scl_w = ~((~scl_oe_n & ~scl_out) | p_scl_low);
	wire  sda_w = ~((~sda_oe_n & ~sda_out) | p_sda_low);
	int   error_cnt, cmp_count, cyc;

	i2c_arb_master #(.QUARTER_CYC(40)) i_i2c_arb_master (
		.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .link_clk(link_clk),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.port_enable(port_enable), .event_ie(event_ie), .start_req(start_req),
		.rstart_req(rstart_req), .stop_req(stop_req), .ack_req(ack_req),
		.ack_data(ack_data), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
		.event_clear(event_clear), .collision_clear(collision_clear),
		.start_seen(start_seen), .stop_seen(stop_seen), .start_pend(start_pend),
		.rstart_pend(rstart_pend), .stop_pend(stop_pend), .ack_pend(ack_pend),
		.buffer_full_flag(buffer_full_flag), .bus_collision_flag(bus_collision_flag),
		.port_event_flag(port_event_flag), .port_irq(port_irq),
		.ack_received(ack_received)
	);

	i2c_bus_partner i_i2c_bus_partner (
		.scl(scl_w), .sda(sda_w), .scl_low(p_scl_low), .sda_low(p_sda_low)
	);

	// ------------------------------------------------------------
	// clocks and timeout
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		link_clk = 1'b0;
		#3;
		forever #40 link_clk = ~link_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt = error_cnt + 1;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task conclude();
		$display("checks %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task check(input logic got, input logic exp, input string what);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	function logic pick(input int k);
		case (k)
			0: return start_pend;
			1: return rstart_pend;
			2: return stop_pend;
			3: return buffer_full_flag;
			4: return bus_collision_flag;
			default: return port_event_flag;
		endcase
	endfunction

	// bounded wait, returns just after a settled edge
	task wait_for(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(k) !== v && n < lim) begin
			@(posedge sys_clk);
			#1;
			n = n + 1;
		end
		check(pick(k), v, "wait ran out");
	endtask

	task pulse(input int k);
		@(posedge sys_clk);
		case (k)
			0: start_req <= 1'b1;
			1: rstart_req <= 1'b1;
			2: stop_req <= 1'b1;
			3: event_clear <= 1'b1;
			default: collision_clear <= 1'b1;
		endcase
		@(posedge sys_clk);
		{start_req, rstart_req, stop_req, event_clear, collision_clear} <= 5'h00;
		// let the request bit settle before anyone looks at it
		#1;
	endtask

	task send(input logic [7:0] d);
		@(posedge sys_clk);
		buf_wdata <= d;
		buf_wr    <= 1'b1;
		@(posedge sys_clk);
		buf_wr    <= 1'b0;
		#1;
	endtask

	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{start_req, rstart_req, stop_req, ack_req, event_clear, collision_clear} = 6'h00;
		{port_enable, event_ie, ack_data, buf_wr} = 4'h0;
		buf_wdata = 8'h00;
		reset     = 1'b1;
		error_cnt = 0;
		cmp_count = 0;
		// eleven edges always span a link edge, too few for the monitor reset, which takes three link edges
		settle(11);
		check(sda_oe_n & scl_oe_n, 1'b1, "lines held after reset");
		check(start_seen | stop_seen, 1'b0, "seen flags after reset");
		check(bus_collision_flag | buffer_full_flag, 1'b0, "flags after reset");
		@(posedge sys_clk);
		reset       <= 1'b0;
		port_enable <= 1'b1;
		event_ie    <= 1'b1;
		settle(20);
		$display("test reset done");

		pulse(0);
		wait_for(0, 1'b0, 400);
		check(start_seen, 1'b1, "start not seen");
		i_i2c_bus_partner.ack_en = 1'b0;
		send(8'h5a);
		wait_for(3, 1'b0, 3000);
		check(i_i2c_bus_partner.got === 8'h5a, 1'b1, "byte on wire");
		check(ack_received, 1'b1, "nack not seen");
		i_i2c_bus_partner.ack_en = 1'b1;
		pulse(2);
		wait_for(2, 1'b0, 400);
		check(stop_seen & ~start_seen, 1'b1, "stop not seen");
		$display("test transfer done");

		i_i2c_bus_partner.pull_sda();
		settle(60);
		check(start_seen & ~stop_seen, 1'b1, "rival start");
		pulse(0);
		settle(300);
		check(start_pend & sda_oe_n, 1'b1, "start taken on busy bus");
		i_i2c_bus_partner.free_sda();
		wait_for(0, 1'b0, 600);
		$display("test busy bus done");

		i_i2c_bus_partner.grab_at = 4'h3;
		send(8'hff);
		wait_for(4, 1'b1, 3000);
		i_i2c_bus_partner.grab_at = 4'hf;
		check(buffer_full_flag, 1'b0, "buffer full kept");
		check(sda_oe_n & scl_oe_n, 1'b1, "lines not released");
		send(8'h33);
		settle(200);
		check(buffer_full_flag, 1'b0, "write taken with collision");
		check(bus_collision_flag, 1'b1, "collision not sticky");
		pulse(3);
		settle(4);
		i_i2c_bus_partner.free_sda();
		wait_for(5, 1'b1, 200);
		check(stop_seen, 1'b1, "stop after loss");
		settle(1);
		check(port_irq, 1'b1, "stop interrupt");
		$display("test byte collision done");

		pulse(4);
		settle(2);
		check(bus_collision_flag, 1'b0, "collision clear");
		pulse(0);
		wait_for(0, 1'b0, 400);
		send(8'hc3);
		wait_for(3, 1'b0, 3000);
		check(i_i2c_bus_partner.got === 8'hc3, 1'b1, "restart byte");
		check(ack_received, 1'b0, "ack lost");
		pulse(2);
		wait_for(2, 1'b0, 400);
		$display("test resume done");

		pulse(0);
		wait_for(0, 1'b0, 400);
		i_i2c_bus_partner.pull_sda();
		pulse(1);
		wait_for(4, 1'b1, 600);
		check(rstart_pend, 1'b0, "rstart request kept");
		check(sda_oe_n & scl_oe_n, 1'b1, "lines after abort");
		i_i2c_bus_partner.free_sda();
		settle(60);
		pulse(4);
		$display("test condition collision done");

		pulse(0);
		wait_for(0, 1'b0, 400);
		send(8'h0f);
		settle(300);
		@(posedge sys_clk);
		port_enable <= 1'b0;
		settle(3);
		check(buffer_full_flag, 1'b0, "buffer after disable");
		check(sda_oe_n & scl_oe_n, 1'b1, "lines after disable");
		check(start_seen | stop_seen, 1'b0, "seen flags when off");
		$display("test disable done");
		conclude();
	end
endmodule
